// ==== pcac_pkg.sv ====
package pcac_pkg;
   // target address on the serial bus
   localparam logic [6:0] I2C_ADDR       = 7'h39;
   // register offsets
   localparam logic [7:0] ADDR_STATUS    = 8'h93;
   localparam logic [7:0] ADDR_PROX      = 8'h9c;
   localparam logic [7:0] ADDR_OFS_MAG   = 8'hc0;
   localparam logic [7:0] ADDR_OFS_SIGN  = 8'hc1;
   localparam logic [7:0] ADDR_CAL_CTRL  = 8'hd7;
   localparam logic [7:0] ADDR_CAL_CFG   = 8'hd9;
   localparam logic [7:0] ADDR_CAL_STAT  = 8'hdc;
   localparam logic [7:0] ADDR_INT_EN    = 8'hdd;
   // field positions
   localparam int         CFG_TGT_MSB    = 7;
   localparam int         CFG_TGT_LSB    = 5;
   localparam int         CFG_TRIM_BIT   = 3;
   localparam int         CFG_AVG_MSB    = 2;
   localparam int         CFG_AVG_LSB    = 0;
   localparam int         CTRL_ELEC_BIT  = 5;
   localparam int         CTRL_START_BIT = 0;
   localparam int         CSTAT_DONE_BIT = 0;
   localparam int         SIGN_BIT       = 0;
   localparam int         IEN_LSAT_BIT   = 7;
   localparam int         IEN_PSAT_BIT   = 6;
   localparam int         IEN_PTHR_BIT   = 5;
   localparam int         IEN_LIGHT_BIT  = 4;
   localparam int         IEN_CAL_BIT    = 3;
   // reset values and masks
   localparam logic [7:0] CAL_CFG_RST    = 8'h40;
   localparam logic [7:0] REG_ZERO       = 8'h00;
   localparam logic [7:0] CTRL_RW_MASK   = 8'h3f;
   localparam logic [7:0] IRQ_MASK       = 8'hf8;
   // offset search
   localparam int         SEARCH_MSB     = 8;
   localparam logic [9:0] OFS_BIAS       = 10'h0ff;
   localparam logic [8:0] SEARCH_FIRST   = 9'h100;
   localparam logic [7:0] OFS_MAX        = 8'hff;
   localparam logic [7:0] ONE8           = 8'h01;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

   typedef enum logic [4:0] {
      PCAC_I2C_IDLE = 5'b00001,
      PCAC_I2C_RX   = 5'b00010,
      PCAC_I2C_ACK  = 5'b00100,
      PCAC_I2C_TX   = 5'b01000,
      PCAC_I2C_RACK = 5'b10000
   } pcac_i2c_e;

   typedef enum logic [1:0] {
      PCAC_CAL_IDLE = 2'b01,
      PCAC_CAL_RUN  = 2'b10
   } pcac_cal_e;
endpackage : pcac_pkg

// ==== pcac_i2c_target.sv ====
`timescale 1ns/10ps
module pcac_i2c_target
   import pcac_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [7:0] rdata_i,
   output logic            sda_oe_o,
   output logic            wr_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o
);
   logic       scl_m, scl_s, scl_d;
   logic       sda_m, sda_s, sda_d;
   pcac_i2c_e  state;
   logic [7:0] shreg;
   logic [3:0] cnt;
   logic [1:0] byte_no;
   logic       is_read;
   logic       pend;

   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
   wire byte_full = (cnt == BITS_PER_BYTE);
   wire addr_hit  = (shreg[7:1] == I2C_ADDR);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state    <= PCAC_I2C_IDLE;
         shreg    <= REG_ZERO;
         cnt      <= 4'h0;
         byte_no  <= 2'h0;
         is_read  <= 1'b0;
         pend     <= 1'b0;
         sda_oe_o <= 1'b0;
         wr_o     <= 1'b0;
         addr_o   <= REG_ZERO;
         wdata_o  <= REG_ZERO;
      end else begin
         wr_o <= 1'b0;
         if (bus_start) begin
            // repeated start keeps the pointer for combined write-then-read
            state    <= PCAC_I2C_RX;
            cnt      <= 4'h0;
            byte_no  <= 2'h0;
            sda_oe_o <= 1'b0;
         end else if (bus_stop) begin
            state    <= PCAC_I2C_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            unique case (state)
               PCAC_I2C_IDLE: begin
               end
               PCAC_I2C_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt   <= cnt + 4'h1;
                  end else if (scl_fall && byte_full) begin
                     if (byte_no == 2'h0) begin
                        if (addr_hit) begin
                           is_read  <= shreg[0];
                           byte_no  <= 2'h1;
                           state    <= PCAC_I2C_ACK;
                           sda_oe_o <= 1'b1;
                        end else begin
                           state <= PCAC_I2C_IDLE;
                        end
                     end else begin
                        if (byte_no == 2'h1) begin
                           addr_o <= shreg;
                        end else begin
                           wr_o    <= 1'b1;
                           wdata_o <= shreg;
                           pend    <= 1'b1;
                        end
                        byte_no  <= 2'h2;
                        state    <= PCAC_I2C_ACK;
                        sda_oe_o <= 1'b1;
                     end
                  end
               end
               PCAC_I2C_ACK: begin
                  if (scl_fall) begin
                     cnt <= 4'h0;
                     if (is_read) begin
                        shreg    <= rdata_i;
                        sda_oe_o <= ~rdata_i[7];
                        addr_o   <= addr_o + ONE8;
                        state    <= PCAC_I2C_TX;
                     end else begin
                        sda_oe_o <= 1'b0;
                        state    <= PCAC_I2C_RX;
                        pend     <= 1'b0;
                        if (pend) begin
                           addr_o <= addr_o + ONE8;
                        end
                     end
                  end
               end
               PCAC_I2C_TX: begin
                  if (scl_rise) begin
                     cnt <= cnt + 4'h1;
                  end else if (scl_fall) begin
                     if (byte_full) begin
                        sda_oe_o <= 1'b0;
                        state    <= PCAC_I2C_RACK;
                     end else begin
                        shreg    <= {shreg[6:0], 1'b0};
                        sda_oe_o <= ~shreg[6];
                     end
                  end
               end
               PCAC_I2C_RACK: begin
                  // a not-acknowledge ends the read
                  if (scl_rise && sda_s) begin
                     state <= PCAC_I2C_IDLE;
                  end else if (scl_fall) begin
                     cnt      <= 4'h0;
                     shreg    <= rdata_i;
                     sda_oe_o <= ~rdata_i[7];
                     addr_o   <= addr_o + ONE8;
                     state    <= PCAC_I2C_TX;
                  end
               end
               default: state <= PCAC_I2C_IDLE;
            endcase
         end
      end
   end
endmodule : pcac_i2c_target

// ==== pcac_top.sv ====
`timescale 1ns/10ps
module pcac_top
   import pcac_pkg::*;
(
   input  wire logic       CLOCK_I,
   input  wire logic       RST_N_I,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE_O,
   output logic            INT_N_O,
   output logic            INT_N_OE_O,
   input  wire logic [7:0] SAMPLE_I,
   input  wire logic       SAMPLE_VALID_I,
   input  wire logic       LIGHT_SAT_EVT_I,
   input  wire logic       PROX_SAT_EVT_I,
   input  wire logic       PROX_THR_EVT_I,
   input  wire logic       LIGHT_EVT_I,
   output logic [7:0]      PROX_RESULT_O,
   output logic            PROX_DONE_O,
   output logic [7:0]      OFFSET_MAG_O,
   output logic            OFFSET_SIGN_O,
   output logic            PD_DISCONNECT_O
);
   logic        bus_wr;
   logic [7:0]  bus_addr;
   logic [7:0]  bus_wdata;
   logic [7:0]  calibration_config;
   logic [7:0]  calibration_control;
   logic [7:0]  interrupt_enables;
   logic [7:0]  status;
   logic        calibration_done_flag;
   logic [7:0]  offset_magnitude;
   logic [7:0]  offset_sign_register;
   logic [14:0] acc;
   logic [7:0]  sample_cnt;
   pcac_cal_e   cal_state;
   logic [8:0]  cal_k;
   logic [3:0]  cal_bit;
   wire  [7:0]  rd_data;

   pcac_i2c_target u_link (
      .clk_i    (CLOCK_I),
      .rst_n_i  (RST_N_I),
      .scl_i    (SCL_I),
      .sda_i    (SDA_I),
      .rdata_i  (rd_data),
      .sda_oe_o (SDA_OE_O),
      .wr_o     (bus_wr),
      .addr_o   (bus_addr),
      .wdata_o  (bus_wdata)
   );

   // register decode
   wire wr_cfg   = bus_wr & (bus_addr == ADDR_CAL_CFG);
   wire wr_ctrl  = bus_wr & (bus_addr == ADDR_CAL_CTRL);
   wire wr_ien   = bus_wr & (bus_addr == ADDR_INT_EN);
   wire wr_stat  = bus_wr & (bus_addr == ADDR_STATUS);
   wire wr_cstat = bus_wr & (bus_addr == ADDR_CAL_STAT);
   wire wr_mag   = bus_wr & (bus_addr == ADDR_OFS_MAG);
   wire wr_sign  = bus_wr & (bus_addr == ADDR_OFS_SIGN);

   assign rd_data =
      (bus_addr == ADDR_CAL_CFG)  ? calibration_config :
      (bus_addr == ADDR_CAL_CTRL) ? calibration_control :
      (bus_addr == ADDR_INT_EN)   ? interrupt_enables :
      (bus_addr == ADDR_STATUS)   ? status :
      (bus_addr == ADDR_CAL_STAT) ? {7'h00, calibration_done_flag} :
      (bus_addr == ADDR_OFS_MAG)  ? offset_magnitude :
      (bus_addr == ADDR_OFS_SIGN) ? offset_sign_register :
      (bus_addr == ADDR_PROX)     ? PROX_RESULT_O : REG_ZERO;

   // averaging: 2^code samples, code 0 takes a single sample
   wire [2:0]  avg_code   = calibration_config[CFG_AVG_MSB:CFG_AVG_LSB];
   wire [7:0]  avg_need   = ONE8 << avg_code;
   wire [7:0]  cnt_next   = sample_cnt + ONE8;
   wire [14:0] acc_next   = acc + {7'h00, SAMPLE_I};
   wire [14:0] acc_shift  = acc_next >> avg_code;
   wire [7:0]  cycle_res  = acc_shift[7:0];

   // search target and acceptance test
   wire [2:0]  tgt_code   = calibration_config[CFG_TGT_MSB:CFG_TGT_LSB];
   wire [7:0]  target     = (ONE8 << tgt_code) - ONE8;
   wire [7:0]  floor_val  = (target == REG_ZERO) ? ONE8 : target;
   wire        keep_bit   = (cycle_res >= floor_val);
   wire        cal_busy   = (cal_state == PCAC_CAL_RUN);
   wire        cal_kick   = (cal_state == PCAC_CAL_IDLE) & calibration_control[CTRL_START_BIT];
   // a sample landing in the kick cycle is dropped, not counted
   wire        cycle_end  = SAMPLE_VALID_I & ~cal_kick & (cnt_next == avg_need);
   wire        cal_judge  = cal_busy & cycle_end;
   wire        cal_last   = cal_judge & (cal_bit == 4'h0);
   // each new trial restarts the average so no stale samples mix in
   wire        cal_step   = cal_kick | (cal_judge & ~cal_last);
   wire [8:0]  k_clear    = cal_k & ~(9'h001 << cal_bit);
   wire [8:0]  k_judged   = keep_bit ? cal_k : k_clear;
   wire [8:0]  k_trial    = k_judged | (9'h001 << (cal_bit - 4'h1));

   // search index k maps onto offset k-255, magnitude clamped at 255
   wire [9:0]  ofs_trial  = {1'b0, cal_k} - OFS_BIAS;
   wire [9:0]  ofs_final  = {1'b0, k_judged} - OFS_BIAS;
   wire [9:0]  abs_trial  = ofs_trial[9] ? (10'h000 - ofs_trial) : ofs_trial;
   wire [9:0]  abs_final  = ofs_final[9] ? (10'h000 - ofs_final) : ofs_final;
   wire [7:0]  mag_trial  = abs_trial[8] ? OFS_MAX : abs_trial[7:0];
   wire [7:0]  mag_final  = abs_final[8] ? OFS_MAX : abs_final[7:0];

   wire        trim_hit   = cycle_end & ~cal_busy & calibration_config[CFG_TRIM_BIT]
                            & (cycle_res == REG_ZERO) & (offset_magnitude != REG_ZERO);

   wire [7:0]  evt_set    = {LIGHT_SAT_EVT_I, PROX_SAT_EVT_I, PROX_THR_EVT_I,
                             LIGHT_EVT_I, cal_last, 3'h0};
   wire [7:0]  stat_clr   = wr_stat ? bus_wdata : REG_ZERO;
   wire [7:0]  next_stat  = ((status & ~stat_clr) | evt_set) & IRQ_MASK;
   wire        next_done  = (calibration_done_flag
                             & ~(wr_cstat & bus_wdata[CSTAT_DONE_BIT])) | cal_last;

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         calibration_config <= CAL_CFG_RST;
         interrupt_enables  <= REG_ZERO;
         status             <= REG_ZERO;
         calibration_done_flag <= 1'b0;
      end else begin
         if (wr_cfg) begin
            calibration_config <= bus_wdata;
         end
         if (wr_ien) begin
            interrupt_enables <= bus_wdata;
         end
         // hardware set wins over a same-cycle clear
         status                <= next_stat;
         calibration_done_flag <= next_done;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         calibration_control <= REG_ZERO;
      end else if (cal_last) begin
         calibration_control[CTRL_START_BIT] <= 1'b0;
      end else if (wr_ctrl && !cal_busy) begin
         // start bit cannot be cleared by the host mid-search
         calibration_control <= bus_wdata & CTRL_RW_MASK;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         cal_state <= PCAC_CAL_IDLE;
         cal_k     <= 9'h000;
         cal_bit   <= 4'h0;
      end else begin
         unique case (cal_state)
            PCAC_CAL_IDLE: begin
               if (cal_kick) begin
                  cal_k     <= SEARCH_FIRST;
                  cal_bit   <= 4'(SEARCH_MSB);
                  cal_state <= PCAC_CAL_RUN;
               end
            end
            PCAC_CAL_RUN: begin
               if (cal_last) begin
                  cal_k     <= k_judged;
                  cal_state <= PCAC_CAL_IDLE;
               end else if (cal_judge) begin
                  cal_k   <= k_trial;
                  cal_bit <= cal_bit - 4'h1;
               end
            end
            default: cal_state <= PCAC_CAL_IDLE;
         endcase
      end
   end

   // offsets: calibration result and trim take priority over a host write
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         offset_magnitude     <= REG_ZERO;
         offset_sign_register <= REG_ZERO;
      end else if (cal_last) begin
         offset_magnitude                 <= mag_final;
         offset_sign_register[SIGN_BIT]   <= ofs_final[9];
      end else if (trim_hit) begin
         offset_magnitude <= offset_magnitude - ONE8;
      end else begin
         if (wr_mag) begin
            offset_magnitude <= bus_wdata;
         end
         if (wr_sign) begin
            offset_sign_register <= bus_wdata;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         acc           <= 15'h0000;
         sample_cnt    <= REG_ZERO;
         PROX_RESULT_O <= REG_ZERO;
         PROX_DONE_O   <= 1'b0;
      end else begin
         PROX_DONE_O <= cycle_end;
         if (cycle_end) begin
            PROX_RESULT_O <= cycle_res;
         end
         if (cal_step || cycle_end) begin
            acc        <= 15'h0000;
            sample_cnt <= REG_ZERO;
         end else if (SAMPLE_VALID_I) begin
            acc        <= acc_next;
            sample_cnt <= cnt_next;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         OFFSET_MAG_O    <= REG_ZERO;
         OFFSET_SIGN_O   <= 1'b0;
         PD_DISCONNECT_O <= 1'b0;
         INT_N_O         <= 1'b0;
         INT_N_OE_O      <= 1'b0;
         SDA_O           <= 1'b0;
      end else begin
         // during a search the converter sees the trial offset
         OFFSET_MAG_O    <= cal_busy ? mag_trial : offset_magnitude;
         OFFSET_SIGN_O   <= cal_busy ? ofs_trial[9] : offset_sign_register[SIGN_BIT];
         PD_DISCONNECT_O <= cal_busy & calibration_control[CTRL_ELEC_BIT];
         INT_N_OE_O      <= |(status & interrupt_enables & IRQ_MASK);
      end
   end
endmodule : pcac_top

// ==== pcac_checker.sv ====
`timescale 1ns/10ps
module pcac_checker (
   input  wire logic       CLOCK_I,
   input  wire logic       RST_N_I,
   input  wire logic       SDA_O,
   input  wire logic       INT_N_O,
   input  wire logic       SAMPLE_VALID_I,
   input  wire logic [7:0] PROX_RESULT_O,
   input  wire logic       PROX_DONE_O,
   input  wire logic [7:0] OFFSET_MAG_O,
   input  wire logic       INT_N_OE_O,
   input  wire logic       PD_DISCONNECT_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   // open-drain pins never drive a high level
   int_low_a: assert property (INT_N_O == 1'b0)
      else $error("interrupt pin driven high");
   sda_low_a: assert property (SDA_O == 1'b0)
      else $error("data pin driven high");
   done_cause_a: assert property (PROX_DONE_O |-> $past(SAMPLE_VALID_I))
      else $error("cycle finished without a sample");
   result_hold_a: assert property ($changed(PROX_RESULT_O) |-> PROX_DONE_O)
      else $error("result moved outside a finished cycle");
   trial_step_a: assert property (PD_DISCONNECT_O && $past(PD_DISCONNECT_O)
      && $changed(OFFSET_MAG_O) |-> PROX_DONE_O || $past(PROX_DONE_O) || $past(PROX_DONE_O, 2))
      else $error("trial offset moved between cycles");
   cal_end_a: assert property ($fell(PD_DISCONNECT_O) |-> PROX_DONE_O || $past(PROX_DONE_O))
      else $error("calibration ended without a cycle");
   no_trim_a: assert property (PROX_DONE_O && PROX_RESULT_O != 8'h00 && !PD_DISCONNECT_O
      |=> $stable(OFFSET_MAG_O))
      else $error("magnitude moved after nonzero result");
   trim_step_a: assert property (PROX_DONE_O && PROX_RESULT_O == 8'h00 && !PD_DISCONNECT_O
      |=> OFFSET_MAG_O == $past(OFFSET_MAG_O) || OFFSET_MAG_O == $past(OFFSET_MAG_O) - 8'h01)
      else $error("magnitude trimmed by more than one");
   zero_cycle_c: cover property (PROX_DONE_O && PROX_RESULT_O == 8'h00);
   cal_end_c: cover property ($fell(PD_DISCONNECT_O));
   irq_c: cover property ($rose(INT_N_OE_O));
endmodule : pcac_checker

bind pcac_top pcac_checker pcac_checker_inst (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
   .SDA_O(SDA_O), .INT_N_O(INT_N_O), .SAMPLE_VALID_I(SAMPLE_VALID_I),
   .PROX_RESULT_O(PROX_RESULT_O), .PROX_DONE_O(PROX_DONE_O), .OFFSET_MAG_O(OFFSET_MAG_O),
   .INT_N_OE_O(INT_N_OE_O), .PD_DISCONNECT_O(PD_DISCONNECT_O));

// ==== pcac_host.sv ====
`timescale 1ns/10ps
module pcac_host
   import pcac_pkg::*;
(
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   int miss = 0;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // data moves only in the low phase, so no false start or stop
   task automatic bit_io(input logic b, output logic r);
      #80 sda_low_o = !b;
      #80 scl_o = 1'b1;
      #80 r = sda_i;
      #80 scl_o = 1'b0;
   endtask : bit_io
   task automatic xfer(input logic [7:0] d, input logic a, input logic chk, output logic [7:0] q);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(a, r);
      if (chk && r !== 1'b0) miss++;
   endtask : xfer
   task automatic start();
      #80 sda_low_o = 1'b0;
      #80 scl_o = 1'b1;
      #160 sda_low_o = 1'b1;
      #160 scl_o = 1'b0;
   endtask : start
   task automatic stop();
      #80 sda_low_o = 1'b1;
      #80 scl_o = 1'b1;
      #160 sda_low_o = 1'b0;
      #320;
   endtask : stop
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      start();
      xfer({I2C_ADDR, 1'b0}, 1'b1, 1'b1, q);
      xfer(a, 1'b1, 1'b1, q);
      xfer(d, 1'b1, 1'b1, q);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] q;
      start();
      xfer({I2C_ADDR, 1'b0}, 1'b1, 1'b1, q);
      xfer(a, 1'b1, 1'b1, q);
      start();
      xfer({I2C_ADDR, 1'b1}, 1'b1, 1'b1, q);
      xfer(8'hff, 1'b1, 1'b0, d);
      stop();
   endtask : rd
endmodule : pcac_host

// ==== testbench.sv ====
`timescale 1ns/10ps
`define CHK(act, exp) \
   begin \
      samples_checked++; \
      if ((act) !== (exp)) begin \
         error_cnt++; \
         $display("wrong value at %0t: got %h want %h", $time, act, exp); \
      end \
   end
module testbench
   import pcac_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] sample = 8'h00;
   logic       sample_valid = 1'b0;
   logic [3:0] evt = 4'h0;
   logic       scl, sda_low, sda_oe, sda_o, int_n, int_oe, done, sign, pd;
   logic [7:0] result, mag, q, v, e;
   wire        sda = !(sda_low || sda_oe);
   logic [7:0] exp_q[$];
   logic [15:0] rst_tab[4] = '{16'hd940, 16'hdc00, 16'hdd00, 16'h8000};
   int         error_cnt = 0, samples_checked = 0, seed = 36, cyc = 0, t, o, sum;

   always #20 clk = ~clk;

   pcac_top pcac_top_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE_O(sda_oe), .INT_N_O(int_n), .INT_N_OE_O(int_oe),
      .SAMPLE_I(sample), .SAMPLE_VALID_I(sample_valid), .LIGHT_SAT_EVT_I(evt[3]),
      .PROX_SAT_EVT_I(evt[2]), .PROX_THR_EVT_I(evt[1]), .LIGHT_EVT_I(evt[0]),
      .PROX_RESULT_O(result), .PROX_DONE_O(done), .OFFSET_MAG_O(mag),
      .OFFSET_SIGN_O(sign), .PD_DISCONNECT_O(pd));
   pcac_host pcac_host_inst (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

   task automatic tick();
      @(posedge clk);
      #2;
   endtask : tick
   // converter: fixed base level minus the applied signed offset
   function automatic logic [7:0] conv();
      int r;
      r = 100 - (sign ? -int'(mag) : int'(mag));
      return 8'(r < 0 ? 0 : (r > 255 ? 255 : r));
   endfunction : conv
   task automatic smp(input logic [7:0] d, input logic live);
      tick();
      sample = live ? conv() : d;
      sample_valid = 1'b1;
      tick();
      sample_valid = 1'b0;
      sample = 8'($random(seed));
   endtask : smp
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // outputs are looked at mid-cycle, where they have settled
   always @(negedge clk) begin
      cyc++;
      if (done === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         `CHK(result, e)
      end
      if (cyc == 60000) begin
         error_cnt++;
         print_verdict();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      #2 rst_n = 1'b1;
      repeat (4) tick();
      foreach (rst_tab[i]) begin
         pcac_host_inst.rd(rst_tab[i][15:8], q);
         `CHK(q, rst_tab[i][7:0])
      end
      v = 8'($random(seed));
      pcac_host_inst.wr(ADDR_INT_EN, v);
      pcac_host_inst.rd(ADDR_INT_EN, q);
      `CHK(q & IRQ_MASK, v & IRQ_MASK)
      // each event with its enable, then masked, then cleared
      for (int i = 0; i < 4; i++) begin
         pcac_host_inst.wr(ADDR_INT_EN, 8'(8'h10 << i));
         evt = 4'(1 << i);
         tick();
         evt = 4'h0;
         repeat (3) tick();
         `CHK(int_oe, 1'b1)
         pcac_host_inst.wr(ADDR_INT_EN, 8'h00);
         repeat (3) tick();
         `CHK(int_oe, 1'b0)
         pcac_host_inst.wr(ADDR_STATUS, 8'(8'h10 << i));
      end
      for (int c = 0; c < 8; c++) begin
         pcac_host_inst.wr(ADDR_CAL_CFG, 8'(8'h40 | c));
         sum = 0;
         for (int n = 0; n < (1 << c); n++) begin
            v = 8'($random(seed));
            sum += v;
            if (n == (1 << c) - 1) exp_q.push_back(8'(sum >> c));
            smp(v, 1'b0);
         end
         repeat (4) tick();
      end
      pcac_host_inst.wr(ADDR_OFS_MAG, 8'h03);
      pcac_host_inst.wr(ADDR_CAL_CFG, 8'h48);
      exp_q.push_back(8'h00);
      smp(8'h00, 1'b0);
      repeat (3) tick();
      `CHK(mag, 8'h02)
      exp_q.push_back(8'h05);
      smp(8'h05, 1'b0);
      repeat (3) tick();
      `CHK(mag, 8'h02)
      pcac_host_inst.wr(ADDR_INT_EN, 8'h08);
      for (int c = 0; c < 8; c++) begin
         t = (c == 0) ? 1 : (1 << c) - 1;
         o = 100 - t;
         pcac_host_inst.wr(ADDR_CAL_CFG, 8'(c << 5));
         pcac_host_inst.wr(ADDR_CAL_CTRL, 8'h21);
         `CHK(pd, 1'b1)
         repeat (40) smp(8'h00, 1'b1);
         `CHK(mag, 8'(o < 0 ? -o : o))
         `CHK(sign, 1'(o < 0))
         `CHK(pd, 1'b0)
         `CHK(int_oe, 1'b1)
         exp_q.push_back(8'(t));
         smp(8'h00, 1'b1);
         pcac_host_inst.rd(ADDR_CAL_STAT, q);
         `CHK(q, 8'h01)
         pcac_host_inst.wr(ADDR_CAL_STAT, 8'h00);
         pcac_host_inst.rd(ADDR_CAL_STAT, q);
         `CHK(q, 8'h01)
         pcac_host_inst.wr(ADDR_CAL_STAT, 8'h01);
         pcac_host_inst.rd(ADDR_CAL_STAT, q);
         `CHK(q, 8'h00)
         pcac_host_inst.wr(ADDR_STATUS, 8'h08);
         repeat (3) tick();
         `CHK(int_oe, 1'b0)
      end
      `CHK(pcac_host_inst.miss, 0)
      `CHK(exp_q.size(), 0)
      print_verdict();
   end
endmodule : testbench
